// ==== rtl/scd_pkg.sv ====
package scd_pkg;
	// command byte field positions
	localparam int unsigned CMD_W         = 8;
	localparam int unsigned BIT_EXECUTE   = 7;
	localparam int unsigned BIT_ONE_SHOT  = 6;
	localparam int unsigned BIT_REPEAT    = 5;
	localparam int unsigned BIT_DIR       = 4;
	localparam int unsigned SEL_HI        = 3;
	localparam int unsigned SEL_LO        = 1;
	localparam int unsigned BIT_SLEEP     = 0;
	localparam int unsigned SEL_W         = 3;
	// register select codes
	localparam logic [2:0]  SEL_OFFSET    = 3'h0;
	localparam logic [2:0]  SEL_GAIN      = 3'h1;
	localparam logic [2:0]  SEL_CONFIG    = 3'h2;
	localparam logic [2:0]  SEL_RESULT    = 3'h3;
	localparam logic [2:0]  SEL_SETUP     = 3'h4;
	// special bytes
	localparam logic [7:0]  CMD_NULL      = 8'h00;
	localparam logic [7:0]  CMD_ALL_ONES  = 8'hff;
	// data phase lengths in serial clocks
	localparam int unsigned REG_W         = 24;
	localparam int unsigned SETUP_BITS    = 72;
	localparam int unsigned CNT_W         = 7;
	localparam logic [6:0]  LEN_SINGLE    = 7'h18;
	localparam logic [6:0]  LEN_SETUP     = 7'h48;
	// raw command byte, one word across the crossing
	localparam int unsigned DEC_W         = 8;
endpackage

// ==== rtl/scd_sync.sv ====
`timescale 1ns/10ps
module scd_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         en_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] q_q;
	logic [W-1:0] q_d;

	always_comb begin
		meta_d = en_i ? d_i : meta_q;
		q_d    = en_i ? meta_q : q_q;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			meta_q <= '0;
			q_q    <= '0;
		end else begin
			meta_q <= meta_d;
			q_q    <= q_d;
		end
	end

	assign q_o = q_q;
endmodule

// ==== rtl/scd_decoder.sv ====
// What this block does
// - a command byte whose top bit is 0 is a no-operation and should be all zeros.
// - only bytes whose top bit is 1 are executed as commands.
// - bit 5 set in an executed command with bit 6 clear starts back to back conversions.
// - bit 4 picks the data phase direction, 0 write and 1 read.
// - bits 3 to 1 pick offset, gain, configuration, result or all set-up; 101 to 111 reserved.
// - the conversion result register is read only and a write to it is not carried out.
// - an all-zero byte in continuous mode with the flag option on clears the port flag.
// - after reset the port is in command mode and takes the first eight bits as a command.
// - a register access command (bits 6 and 5 clear, select 000 to 100) is followed by 24 data bits, or 72 for set-up, then command mode again.
// - every register reached by a command is 24 bits wide.
`timescale 1ns/10ps
module scd_decoder #(
	parameter int unsigned REG_WIDTH = scd_pkg::REG_W
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_b_i,
	input  wire logic        clk_en_i,
	input  wire logic        sclk_i,
	input  wire logic        rst_link_b_i,
	input  wire logic        cs_b_i,
	input  wire logic        sdi_i,
	input  wire logic        flag_option_i,
	output logic             cmd_strobe_o,
	output logic             convert_once_o,
	output logic             convert_repeat_o,
	output logic             read_dir_o,
	output logic [2:0]       register_select_o,
	output logic             sleep_o,
	output logic             write_refused_o,
	output logic             reserved_sel_o,
	output logic             flag_clear_o,
	output logic             resync_step_o,
	output logic             data_mode_o
);
	typedef enum logic [1:0] {
		SCD_CMD,
		SCD_DATA
	} scd_mode_t;

	// ---------------- link domain, clocked by the serial clock ----------------
	scd_mode_t              mode_q;
	scd_mode_t              mode_d;
	logic [scd_pkg::CMD_W-1:0] shift_q;
	logic [scd_pkg::CMD_W-1:0] shift_d;
	logic [scd_pkg::CNT_W-1:0] cnt_q;
	logic [scd_pkg::CNT_W-1:0] cnt_d;
	logic [scd_pkg::DEC_W-1:0] cmd_q;
	logic [scd_pkg::DEC_W-1:0] cmd_d;
	logic                   tgl_q;
	logic                   tgl_d;
	logic [scd_pkg::CMD_W-1:0] byte_in;
	logic                   byte_done;

	// chip select gates the serial clock edges; cs high mid-byte keeps the count
	always_comb begin
		mode_d    = mode_q;
		shift_d   = shift_q;
		cnt_d     = cnt_q;
		cmd_d     = cmd_q;
		tgl_d     = tgl_q;
		byte_in   = {shift_q[scd_pkg::CMD_W-2:0], sdi_i};
		byte_done = 1'b0;
		if (!cs_b_i) begin
			unique case (mode_q)
				SCD_CMD: begin
					shift_d = byte_in;
					cnt_d   = cnt_q + 7'h01;
					if (cnt_q == 7'h07) begin
						byte_done = 1'b1;
						cnt_d     = '0;
						cmd_d     = byte_in;
						// only executable register commands open a data phase
						if (byte_in[scd_pkg::BIT_EXECUTE] && byte_in != scd_pkg::CMD_ALL_ONES
							&& !byte_in[scd_pkg::BIT_ONE_SHOT]
							&& !byte_in[scd_pkg::BIT_REPEAT]
							&& byte_in[scd_pkg::SEL_HI:scd_pkg::SEL_LO] <= scd_pkg::SEL_SETUP) begin
							mode_d = SCD_DATA;
						end
					end
				end
				SCD_DATA: begin
					cnt_d = cnt_q + 7'h01;
					if (cnt_q == data_len(cmd_q) - 7'h01) begin
						cnt_d  = '0;
						mode_d = SCD_CMD;
					end
				end
				default: begin
					mode_d = SCD_CMD;
					cnt_d  = '0;
				end
			endcase
		end
		if (byte_done) begin
			tgl_d = ~tgl_q;
		end
	end

	// data phase length: one register word, or three for the set-up group
	function automatic logic [scd_pkg::CNT_W-1:0] data_len(input logic [7:0] c);
		logic [scd_pkg::CNT_W-1:0] n;
		n = scd_pkg::CNT_W'(REG_WIDTH);
		if (c[scd_pkg::SEL_HI:scd_pkg::SEL_LO] == scd_pkg::SEL_SETUP) begin
			n = scd_pkg::CNT_W'(3 * REG_WIDTH);
		end
		return n;
	endfunction

	always_ff @(posedge sclk_i) begin
		if (!rst_link_b_i) begin
			mode_q  <= SCD_CMD;
			shift_q <= '0;
			cnt_q   <= '0;
			cmd_q   <= '0;
			tgl_q   <= 1'b0;
		end else begin
			mode_q  <= mode_d;
			shift_q <= shift_d;
			cnt_q   <= cnt_d;
			cmd_q   <= cmd_d;
			tgl_q   <= tgl_d;
		end
	end

	// ---------------- system domain ----------------
	// the command word is held stable from the toggle until the next byte ends,
	// at least eight serial clocks, so it is sampled once the toggle is seen
	logic                      tgl_s;
	logic                      mode_s;
	logic                      tgl_seen_q;
	logic                      tgl_seen_d;
	logic                      take_q;
	logic                      take_d;
	logic [scd_pkg::DEC_W-1:0] cmd_s_q;
	logic [scd_pkg::DEC_W-1:0] cmd_s_d;
	logic                      repeat_mode_q;
	logic                      repeat_mode_d;

	scd_sync #(
		.W(2)
	) u_sync (
		.clk_i   (clk_sys_i),
		.rst_b_i (rst_b_i),
		.en_i    (clk_en_i),
		.d_i     ({tgl_q, mode_q == SCD_DATA}),
		.q_o     ({tgl_s, mode_s})
	);

	logic                   strobe_q;
	logic                   strobe_d;
	logic                   once_q;
	logic                   once_d;
	logic                   repeat_q;
	logic                   repeat_d;
	logic                   dir_q;
	logic                   dir_d;
	logic [scd_pkg::SEL_W-1:0] sel_q;
	logic [scd_pkg::SEL_W-1:0] sel_d;
	logic                   sleep_q;
	logic                   sleep_d;
	logic                   refuse_q;
	logic                   refuse_d;
	logic                   rsv_q;
	logic                   rsv_d;
	logic                   fclr_q;
	logic                   fclr_d;
	logic                   resync_q;
	logic                   resync_d;
	logic                   dmode_q;
	logic                   dmode_d;
	logic                   exec;
	logic                   is_null;
	// sample the word one cycle after the toggle edge is seen
	logic                   strobe_pending_q;

	always_comb begin
		tgl_seen_d    = tgl_s;
		take_d        = tgl_s != tgl_seen_q;
		cmd_s_d       = take_q ? cmd_q : cmd_s_q;
		repeat_mode_d = repeat_mode_q;
		strobe_d      = 1'b0;
		once_d        = 1'b0;
		refuse_d      = 1'b0;
		rsv_d         = 1'b0;
		fclr_d        = 1'b0;
		resync_d      = 1'b0;
		repeat_d      = repeat_q;
		dir_d         = dir_q;
		sel_d         = sel_q;
		sleep_d       = sleep_q;
		dmode_d       = mode_s;
		is_null       = cmd_s_q == scd_pkg::CMD_NULL;
		exec          = cmd_s_q[scd_pkg::BIT_EXECUTE] && cmd_s_q != scd_pkg::CMD_ALL_ONES;
		if (strobe_pending_q) begin
			if (cmd_s_q == scd_pkg::CMD_ALL_ONES) begin
				resync_d = 1'b1;
			end else if (!cmd_s_q[scd_pkg::BIT_EXECUTE]) begin
				// non-zero bytes with the top bit clear are still ignored
				if (is_null && repeat_mode_q && flag_option_i) begin
					fclr_d = 1'b1;
				end
			end else if (exec) begin
				strobe_d = 1'b1;
				sleep_d  = cmd_s_q[scd_pkg::BIT_SLEEP];
				if (cmd_s_q[scd_pkg::BIT_ONE_SHOT]) begin
					once_d        = 1'b1;
					repeat_mode_d = 1'b0;
				end else if (cmd_s_q[scd_pkg::BIT_REPEAT]) begin
					repeat_mode_d = 1'b1;
				end else begin
					dir_d = cmd_s_q[scd_pkg::BIT_DIR];
					sel_d = cmd_s_q[scd_pkg::SEL_HI:scd_pkg::SEL_LO];
					rsv_d = cmd_s_q[scd_pkg::SEL_HI:scd_pkg::SEL_LO] > scd_pkg::SEL_SETUP;
					refuse_d = !cmd_s_q[scd_pkg::BIT_DIR]
						&& cmd_s_q[scd_pkg::SEL_HI:scd_pkg::SEL_LO] == scd_pkg::SEL_RESULT;
				end
			end
		end
		repeat_d = repeat_mode_d;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			tgl_seen_q       <= 1'b0;
			take_q           <= 1'b0;
			strobe_pending_q <= 1'b0;
			cmd_s_q          <= '0;
			repeat_mode_q    <= 1'b0;
			strobe_q         <= 1'b0;
			once_q           <= 1'b0;
			repeat_q         <= 1'b0;
			dir_q            <= 1'b0;
			sel_q            <= '0;
			sleep_q          <= 1'b0;
			refuse_q         <= 1'b0;
			rsv_q            <= 1'b0;
			fclr_q           <= 1'b0;
			resync_q         <= 1'b0;
			dmode_q          <= 1'b0;
		end else if (clk_en_i) begin
			tgl_seen_q       <= tgl_seen_d;
			take_q           <= take_d;
			strobe_pending_q <= take_q;
			cmd_s_q          <= cmd_s_d;
			repeat_mode_q    <= repeat_mode_d;
			strobe_q         <= strobe_d;
			once_q           <= once_d;
			repeat_q         <= repeat_d;
			dir_q            <= dir_d;
			sel_q            <= sel_d;
			sleep_q          <= sleep_d;
			refuse_q         <= refuse_d;
			rsv_q            <= rsv_d;
			fclr_q           <= fclr_d;
			resync_q         <= resync_d;
			dmode_q          <= dmode_d;
		end
	end

	assign cmd_strobe_o      = strobe_q;
	assign convert_once_o    = once_q;
	assign convert_repeat_o  = repeat_q;
	assign read_dir_o        = dir_q;
	assign register_select_o = sel_q;
	assign sleep_o           = sleep_q;
	assign write_refused_o   = refuse_q;
	assign reserved_sel_o    = rsv_q;
	assign flag_clear_o      = fclr_q;
	assign resync_step_o     = resync_q;
	assign data_mode_o       = dmode_q;
endmodule

// ==== tb/scd_decoder_props.sv ====
`timescale 1ns/10ps
module scd_decoder_props (
	input wire logic       clk_sys_i,
	input wire logic       rst_b_i,
	input wire logic       flag_option_i,
	input wire logic       cmd_strobe_o,
	input wire logic       convert_once_o,
	input wire logic       convert_repeat_o,
	input wire logic [2:0] register_select_o,
	input wire logic       sleep_o,
	input wire logic       write_refused_o,
	input wire logic       reserved_sel_o,
	input wire logic       flag_clear_o,
	input wire logic       resync_step_o,
	input wire logic       data_mode_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	// bytes arrive at least 8 link clocks apart, about 12.8 system cycles here, more than 8
	sequence s_quiet;
		!cmd_strobe_o [*8];
	endsequence
	sequence s_cmd;
		cmd_strobe_o || $past(cmd_strobe_o);
	endsequence
	a_once_strobe: assert property (convert_once_o |-> cmd_strobe_o)
		else $error("single conversion without command");
	a_strobe_gap: assert property (cmd_strobe_o |=> s_quiet)
		else $error("command pulse repeated");
	a_repeat_rise: assert property ($rose(convert_repeat_o) |-> s_cmd)
		else $error("continuous mode set without command");
	a_repeat_stop: assert property ($fell(convert_repeat_o) |->
		convert_once_o || $past(convert_once_o))
		else $error("continuous mode left without single command");
	a_flag_clear: assert property (flag_clear_o |->
		convert_repeat_o && flag_option_i && !cmd_strobe_o)
		else $error("flag clear out of continuous mode");
	a_resync_only: assert property (resync_step_o |->
		!(cmd_strobe_o || reserved_sel_o || convert_once_o))
		else $error("all ones byte decoded as command");
	a_sleep_cmd: assert property ($changed(sleep_o) |-> s_cmd)
		else $error("sleep changed without command");
	a_select_cmd: assert property ($changed(register_select_o) |-> s_cmd)
		else $error("select changed without command");
	a_data_quiet: assert property (data_mode_o |->
		!(convert_once_o || resync_step_o || reserved_sel_o))
		else $error("command decoded in data phase");
	a_refused_alone: assert property (write_refused_o |-> !(convert_once_o || reserved_sel_o))
		else $error("refused write mixed with other command");
endmodule

bind scd_decoder scd_decoder_props u_props (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
	.flag_option_i(flag_option_i), .cmd_strobe_o(cmd_strobe_o), .convert_once_o(convert_once_o),
	.convert_repeat_o(convert_repeat_o), .register_select_o(register_select_o), .sleep_o(sleep_o),
	.write_refused_o(write_refused_o), .reserved_sel_o(reserved_sel_o),
	.flag_clear_o(flag_clear_o), .resync_step_o(resync_step_o), .data_mode_o(data_mode_o));

// ==== tb/scd_host_model.sv ====
`timescale 1ns/10ps
module scd_host_model (
	output logic sclk_o,
	output logic cs_b_o,
	output logic sdi_o
);
	initial begin
		sclk_o = 1'b0;
		cs_b_o = 1'b1;
		sdi_o = 1'b0;
	end
	task automatic tick(input logic b);
		sdi_o = b;
		#16 sclk_o = 1'b1;
		#16 sclk_o = 1'b0;
	endtask
	task automatic send_byte(input logic [7:0] v);
		cs_b_o = 1'b0;
		for (int i = 7; i >= 0; i--) tick(v[i]);
	endtask
	task automatic send24(input logic [23:0] v);
		cs_b_o = 1'b0;
		for (int i = 23; i >= 0; i--) tick(v[i]);
	endtask
	// released line must not keep showing the last bit
	task automatic release_port();
		cs_b_o = 1'b1;
		sdi_o = ~sdi_o;
		#64;
	endtask
	task automatic idle_clocks(input int n);
		repeat (n) tick(~sdi_o);
	endtask
endmodule

// ==== tb/scd_decoder_tb.sv ====
`timescale 1ns/10ps
module scd_decoder_tb;
	logic        clk_sys_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        rst_link_b_i = 1'b0;
	logic        flag_option_i = 1'b0;
	logic        sclk, cs_b, sdi, strobe, once, rep, rd, slp, refu, resv, fclr, rsy, dmode;
	logic [2:0]  sel;
	logic [23:0] q[$];
	int          num_errors = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	logic        m_rep = 1'b0;
	logic        m_slp = 1'b0;
	logic        m_rd = 1'b0;
	logic [2:0]  m_sel = 3'h0;

	always #10 clk_sys_i = ~clk_sys_i;

	scd_host_model u_scd_host_model (.sclk_o(sclk), .cs_b_o(cs_b), .sdi_o(sdi));
	scd_decoder u_scd_decoder (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1),
		.sclk_i(sclk), .rst_link_b_i(rst_link_b_i), .cs_b_i(cs_b), .sdi_i(sdi),
		.flag_option_i(flag_option_i), .cmd_strobe_o(strobe), .convert_once_o(once),
		.convert_repeat_o(rep), .read_dir_o(rd), .register_select_o(sel), .sleep_o(slp),
		.write_refused_o(refu), .reserved_sel_o(resv), .flag_clear_o(fclr),
		.resync_step_o(rsy), .data_mode_o(dmode));

	task automatic check(input string n, input logic [5:0] s, input logic [5:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wrap_up();
		if (num_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	// note layout: pulses, pulse mask, levels, level mask
	always @(posedge clk_sys_i) begin
		logic [5:0]  p;
		logic [23:0] n;
		#1;
		p = {strobe, once, refu, resv, fclr, rsy};
		if (p !== 6'h00) begin
			n = (q.size() > 0) ? q.pop_front() : 24'hffffff;
			check("pulses", p & n[17:12], n[23:18] & n[17:12]);
			check("levels", {rep, slp, rd, sel} & n[5:0], n[11:6] & n[5:0]);
		end
	end

	task automatic issue(input logic [7:0] b);
		logic [5:0] pe, pm, lm;
		pe = 6'h00;
		pm = 6'h3f;
		lm = 6'h30;
		if (b == 8'hff) begin
			pe = 6'h01;
			lm = 6'h00;
		end else if (!b[7]) begin
			pe = {4'h0, b == 8'h00 && m_rep && flag_option_i, 1'b0};
			lm = 6'h00;
		end else begin
			if (b[5]) m_rep = 1'b1;
			if (b[6]) m_rep = 1'b0;
			m_slp = b[0];
			pe = {1'b1, b[6], 4'h0};
			if (!b[6] && !b[5]) begin
				if (b[3:1] > 3'h4) begin
					pe[2] = 1'b1;
					lm = 6'h00;
				end else if (b[3:1] == 3'h3 && !b[4]) begin
					pe[3] = 1'b1;
					lm = 6'h00;
				end else begin
					m_rd = b[4];
					m_sel = b[3:1];
					lm = 6'h3f;
				end
			end
		end
		if (pe != 6'h00) q.push_back({pe, pm, m_rep, m_slp, m_rd, m_sel, lm});
		u_scd_host_model.send_byte(b);
		if (b[7:5] == 3'b100 && b[3:1] <= 3'h4) begin
			repeat (b[3:1] == 3'h4 ? 3 : 1) u_scd_host_model.send24(24'($urandom));
			check("data_mode", {5'h00, dmode}, 6'h01);
		end
		u_scd_host_model.release_port();
		repeat (12) @(posedge clk_sys_i);
		check("data_mode", {5'h00, dmode}, 6'h00);
	endtask

	initial begin
		void'($urandom(32'hb3900c32));
		// link reset only completes on link clock edges
		fork
			u_scd_host_model.idle_clocks(2);
			repeat (4) @(posedge clk_sys_i);
		join
		rst_b_i <= 1'b1;
		rst_link_b_i <= 1'b1;
		issue(8'hc0);
		issue(8'ha0);
		flag_option_i <= 1'b1;
		// the note for the next byte reads the option, so let it settle first
		@(posedge clk_sys_i);
		issue(8'h00);
		issue(8'h7f);
		issue(8'hff);
		issue(8'ha1);
		issue(8'hc0);
		issue(8'h00);
		for (int i = 0; i < 16; i++) issue({3'b100, i[0], i[3:1], 1'($urandom)});
		check("pending", 6'(q.size()), 6'h00);
		wrap_up();
	end
endmodule
